/* rtl/ptp_cfg_pkg.sv */
// shared constants and types for the port-one ptp timing configuration block
`default_nettype none
package ptp_cfg_pkg;
   // ---------------------------------------------------------------
   // host port geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned REG_W  = 16;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [10:0] OFF_MSG_CFG2   = 11'h622;
   localparam logic [10:0] OFF_DOMAIN_VER = 11'h624;
   localparam logic [10:0] OFF_RX_LAT     = 11'h640;
   localparam logic [10:0] OFF_TX_LAT     = 11'h642;
   localparam logic [10:0] OFF_ASYM       = 11'h644;
   localparam logic [10:0] OFF_LINK_DLY   = 11'h646;
   localparam logic [10:0] OFF_TS_LOW     = 11'h648;
   localparam logic [10:0] OFF_TS_HIGH    = 11'h64A;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned DOMAIN_EN_BIT = 4;
   localparam int unsigned VER_LSB       = 8;
   localparam int unsigned VER_MSB       = 11;
   localparam int unsigned DOM_MSB       = 7;
   localparam int unsigned ASYM_SIGN_BIT = 15;
   localparam int unsigned ASYM_MAG_W    = 15;
   localparam int unsigned TSH_NS_MSB    = 13;
   localparam int unsigned TSH_SEC_LSB   = 14;
   localparam int unsigned TS_NS_W       = 30;
   localparam int unsigned TS_SEC_W      = 2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [3:0]  RST_VERSION   = 4'h2;
   localparam logic [7:0]  RST_DOMAIN    = 8'h00;
   localparam logic        RST_DOMAIN_EN = 1'b0;
   localparam logic [15:0] RST_RX_LAT    = 16'h019F;
   localparam logic [15:0] RST_TX_LAT    = 16'h002D;
   localparam logic [15:0] RST_ZERO16    = 16'h0000;

   // the only version whose frames may reach the host port
   localparam logic [3:0]  VER_HOST_OK   = 4'h1;

   typedef enum logic [1:0] {
      MSG_SYNC        = 2'b00,
      MSG_DELAY_REQ   = 2'b01,
      MSG_PDELAY_REQ  = 2'b10,
      MSG_PDELAY_RESP = 2'b11
   } ptp_msg_t;

   typedef enum logic [1:0] {
      VERDICT_DROP = 2'b00,
      VERDICT_HOST = 2'b01,
      VERDICT_LINE = 2'b10
   } verdict_t;
endpackage
`default_nettype wire

/* rtl/ptp_rx_filter.sv */
// receive-side version and domain filter for ptp frames
`default_nettype none
module ptp_rx_filter
   import ptp_cfg_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   // frame header
   input  wire logic       pkt_valid_i,
   input  wire logic [3:0] pkt_version_i,
   input  wire logic [7:0] pkt_domain_i,
   // configuration
   input  wire logic [3:0] exp_version_i,
   input  wire logic [7:0] exp_domain_i,
   input  wire logic       domain_en_i,
   // verdict
   output logic            verdict_valid_o,
   output verdict_t        verdict_o
);
   verdict_t next_verdict;
   logic     next_valid;

   always_comb begin
      next_valid   = pkt_valid_i;
      next_verdict = verdict_o;
      if (pkt_valid_i) begin
         if (pkt_version_i != exp_version_i) begin
            next_verdict = VERDICT_DROP;
         end else if (exp_version_i != VER_HOST_OK) begin
            next_verdict = VERDICT_LINE;
         end else if (domain_en_i && (pkt_domain_i != exp_domain_i)) begin
            next_verdict = VERDICT_DROP;
         end else begin
            next_verdict = VERDICT_HOST;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         verdict_valid_o <= 1'b0;
         verdict_o       <= VERDICT_DROP;
      end else begin
         verdict_valid_o <= next_valid;
         verdict_o       <= next_verdict;
      end
   end
endmodule
`default_nettype wire

/* rtl/ptp_asym_adjust.sv */
// applies the signed asymmetry correction to a ptp correction field
`default_nettype none
module ptp_asym_adjust
   import ptp_cfg_pkg::*;
#(
   parameter int unsigned CORR_W = 64
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   // message in
   input  wire logic              msg_valid_i,
   input  wire logic              msg_ingress_i,
   input  wire ptp_msg_t          msg_type_i,
   input  wire logic [CORR_W-1:0] corr_i,
   input  wire logic [15:0]       asym_i,
   // message out
   output logic                   corr_valid_o,
   output logic [CORR_W-1:0]      corr_o
);
   logic [CORR_W-1:0] mag;
   logic [CORR_W-1:0] signed_asym;
   logic [CORR_W-1:0] next_corr;
   logic              next_valid;

   always_comb begin
      mag = {{(CORR_W-ASYM_MAG_W){1'b0}}, asym_i[ASYM_MAG_W-1:0]};
      signed_asym = asym_i[ASYM_SIGN_BIT] ? (~mag + 1'b1) : mag;
      next_valid  = msg_valid_i;
      next_corr   = corr_o;
      if (msg_valid_i) begin
         next_corr = corr_i;
         if (msg_ingress_i &&
             (msg_type_i == MSG_SYNC || msg_type_i == MSG_PDELAY_RESP)) begin
            next_corr = corr_i + signed_asym;
         end else if (!msg_ingress_i &&
             (msg_type_i == MSG_DELAY_REQ || msg_type_i == MSG_PDELAY_REQ)) begin
            next_corr = corr_i - signed_asym;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         corr_valid_o <= 1'b0;
         corr_o       <= '0;
      end else begin
         corr_valid_o <= next_valid;
         corr_o       <= next_corr;
      end
   end
endmodule
`default_nettype wire

/* rtl/ptp_port_timing_config.sv */
// port-one ptp filter, latency, asymmetry and delay-request timestamp registers
`default_nettype none
//
// Function
// - Hold 4-bit expected version, reset 2; capture packets whose version matches it.
// - Drop any received ptp packet whose version differs from the expected version.
// - Versions other than 1 forward between line ports only, never to host.
// - 8-bit expected domain, reset 0; with checking on, version 1 frames with a mismatched domain are dropped.
// - With domain checking off, the received domain number is ignored.
// - Writable 16-bit port-one receive latency in ns, reset 415.
// - Writable 16-bit port-one transmit latency in ns, reset 45.
// - Asymmetry top bit is sign; low fifteen bits are the magnitude.
// - Add signed asymmetry to correction of ingress Sync and Pdelay_Resp.
// - Subtract signed asymmetry from correction of egress Delay_Req and Pdelay_Req.
// - Writable 16-bit port-one link delay in ns, reset 0.
// - Low word shows delay-request egress timestamp nanoseconds 15..0.
// - High word bits 13..0 show timestamp nanoseconds 29..16.
// - High word bits 15..14 show timestamp seconds 1..0.
// - Domain checking enable is bit 4 of message config 2, reset 0.
module ptp_port_timing_config
   import ptp_cfg_pkg::*;
#(
   parameter int unsigned CORR_W = 64
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,

   // host register port
   input  wire logic [10:0]       host_addr_i,
   input  wire logic              host_wr_i,
   input  wire logic              host_rd_i,
   input  wire logic [1:0]        host_be_i,
   input  wire logic [15:0]       host_wdata_i,
   output logic [15:0]            host_rdata_o,
   output logic                   host_rvalid_o,

   // received ptp header for filtering
   input  wire logic              rx_pkt_valid_i,
   input  wire logic [3:0]        rx_pkt_version_i,
   input  wire logic [7:0]        rx_pkt_domain_i,
   output logic                   rx_verdict_valid_o,
   output verdict_t               rx_verdict_o,

   // correction field path
   input  wire logic              corr_valid_i,
   input  wire logic              corr_ingress_i,
   input  wire ptp_msg_t          corr_type_i,
   input  wire logic [CORR_W-1:0] corr_i,
   output logic                   corr_valid_o,
   output logic [CORR_W-1:0]      corr_o,

   // egress timestamp report from the timestamp unit
   input  wire logic              tx_ts_valid_i,
   input  wire ptp_msg_t          tx_ts_type_i,
   input  wire logic [1:0]        tx_ts_sec_i,
   input  wire logic [29:0]       tx_ts_ns_i,

   // settings for the timestamp unit
   output logic [15:0]            rx_latency_o,
   output logic [15:0]            tx_latency_o,
   output logic [15:0]            link_delay_o
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [3:0]  version;
   logic [7:0]  domain;
   logic        domain_en;
   logic [15:0] rx_lat;
   logic [15:0] tx_lat;
   logic [15:0] asym;
   logic [15:0] link_dly;
   logic [15:0] ts_low;
   logic [15:0] ts_high;

   logic [3:0]  next_version;
   logic [7:0]  next_domain;
   logic        next_domain_en;
   logic [15:0] next_rx_lat;
   logic [15:0] next_tx_lat;
   logic [15:0] next_asym;
   logic [15:0] next_link_dly;
   logic [15:0] next_ts_low;
   logic [15:0] next_ts_high;

   logic        wr_lo;
   logic        wr_hi;
   logic        ts_capture;

   // ---------------------------------------------------------------
   // read path state
   // ---------------------------------------------------------------
   logic [15:0] rd_word;
   logic [15:0] next_rdata;
   logic        next_rvalid;

   // ---------------------------------------------------------------
   // byte-lane merge helper
   // ---------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic        lo,
                                           input logic        hi);
      logic [15:0] r;
      r = old_v;
      if (lo) begin
         r[7:0] = new_v[7:0];
      end
      if (hi) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // register write and capture
   // ---------------------------------------------------------------
   always_comb begin
      wr_lo          = host_wr_i & host_be_i[0];
      wr_hi          = host_wr_i & host_be_i[1];
      ts_capture     = tx_ts_valid_i &&
                       (tx_ts_type_i == MSG_DELAY_REQ || tx_ts_type_i == MSG_PDELAY_REQ);
      next_version   = version;
      next_domain    = domain;
      next_domain_en = domain_en;
      next_rx_lat    = rx_lat;
      next_tx_lat    = tx_lat;
      next_asym      = asym;
      next_link_dly  = link_dly;
      next_ts_low    = ts_low;
      next_ts_high   = ts_high;
      case (host_addr_i)
         OFF_MSG_CFG2: begin
            if (wr_lo) begin
               next_domain_en = host_wdata_i[DOMAIN_EN_BIT];
            end
         end
         OFF_DOMAIN_VER: begin
            if (wr_lo) begin
               next_domain = host_wdata_i[DOM_MSB:0];
            end
            if (wr_hi) begin
               next_version = host_wdata_i[VER_MSB:VER_LSB];
            end
         end
         OFF_RX_LAT: begin
            next_rx_lat = merge16(rx_lat, host_wdata_i, wr_lo, wr_hi);
         end
         OFF_TX_LAT: begin
            next_tx_lat = merge16(tx_lat, host_wdata_i, wr_lo, wr_hi);
         end
         OFF_ASYM: begin
            next_asym = merge16(asym, host_wdata_i, wr_lo, wr_hi);
         end
         OFF_LINK_DLY: begin
            next_link_dly = merge16(link_dly, host_wdata_i, wr_lo, wr_hi);
         end
         OFF_TS_LOW: begin
            next_ts_low = merge16(ts_low, host_wdata_i, wr_lo, wr_hi);
         end
         OFF_TS_HIGH: begin
            next_ts_high = merge16(ts_high, host_wdata_i, wr_lo, wr_hi);
         end
         default: begin
         end
      endcase
      // hardware capture wins over a host write in the same cycle
      if (ts_capture) begin
         next_ts_low  = tx_ts_ns_i[15:0];
         next_ts_high = {tx_ts_sec_i[TS_SEC_W-1:0], tx_ts_ns_i[TS_NS_W-1:16]};
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         version   <= RST_VERSION;
         domain    <= RST_DOMAIN;
         domain_en <= RST_DOMAIN_EN;
         rx_lat    <= RST_RX_LAT;
         tx_lat    <= RST_TX_LAT;
         asym      <= RST_ZERO16;
         link_dly  <= RST_ZERO16;
         ts_low    <= RST_ZERO16;
         ts_high   <= RST_ZERO16;
      end else begin
         version   <= next_version;
         domain    <= next_domain;
         domain_en <= next_domain_en;
         rx_lat    <= next_rx_lat;
         tx_lat    <= next_tx_lat;
         asym      <= next_asym;
         link_dly  <= next_link_dly;
         ts_low    <= next_ts_low;
         ts_high   <= next_ts_high;
      end
   end

   // ---------------------------------------------------------------
   // register read
   // ---------------------------------------------------------------
   // odd and unmapped addresses read zero so software never sees stale data
   always_comb begin
      rd_word = RST_ZERO16;
      case (host_addr_i)
         OFF_MSG_CFG2: begin
            rd_word[DOMAIN_EN_BIT] = domain_en;
         end
         OFF_DOMAIN_VER: begin
            rd_word[VER_MSB:VER_LSB] = version;
            rd_word[DOM_MSB:0]       = domain;
         end
         OFF_RX_LAT: begin
            rd_word = rx_lat;
         end
         OFF_TX_LAT: begin
            rd_word = tx_lat;
         end
         OFF_ASYM: begin
            rd_word = asym;
         end
         OFF_LINK_DLY: begin
            rd_word = link_dly;
         end
         OFF_TS_LOW: begin
            rd_word = ts_low;
         end
         OFF_TS_HIGH: begin
            rd_word = ts_high;
         end
         default: begin
            rd_word = RST_ZERO16;
         end
      endcase
      next_rvalid = host_rd_i;
      next_rdata  = host_rd_i ? rd_word : host_rdata_o;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         host_rdata_o  <= RST_ZERO16;
         host_rvalid_o <= 1'b0;
      end else begin
         host_rdata_o  <= next_rdata;
         host_rvalid_o <= next_rvalid;
      end
   end

   // ---------------------------------------------------------------
   // settings toward the timestamp unit
   // ---------------------------------------------------------------
   always_comb begin
      rx_latency_o = rx_lat;
      tx_latency_o = tx_lat;
      link_delay_o = link_dly;
   end

   // ---------------------------------------------------------------
   // receive filter
   // ---------------------------------------------------------------
   // verdict per frame
   ptp_rx_filter u_filter (
      .sys_clk_i       (sys_clk_i),
      .reset_i         (reset_i),
      .pkt_valid_i     (rx_pkt_valid_i),
      .pkt_version_i   (rx_pkt_version_i),
      .pkt_domain_i    (rx_pkt_domain_i),
      .exp_version_i   (version),
      .exp_domain_i    (domain),
      .domain_en_i     (domain_en),
      .verdict_valid_o (rx_verdict_valid_o),
      .verdict_o       (rx_verdict_o)
   );

   // ---------------------------------------------------------------
   // asymmetry correction
   // ---------------------------------------------------------------
   // signed correction
   ptp_asym_adjust #(
      .CORR_W (CORR_W)
   ) u_asym (
      .sys_clk_i     (sys_clk_i),
      .reset_i       (reset_i),
      .msg_valid_i   (corr_valid_i),
      .msg_ingress_i (corr_ingress_i),
      .msg_type_i    (corr_type_i),
      .corr_i        (corr_i),
      .asym_i        (asym),
      .corr_valid_o  (corr_valid_o),
      .corr_o        (corr_o)
   );

endmodule
`default_nettype wire

/* verif/ptp_cfg_monitor.sv */
// assertion checker for the port-one ptp timing configuration block
`default_nettype none
module ptp_cfg_monitor
   import ptp_cfg_pkg::*;
#(
   parameter int unsigned CORR_W = 64
) (
   // clock and reset
   input wire logic              sys_clk_i,
   input wire logic              reset_i,
   // host port
   input wire logic [10:0]       host_addr_i,
   input wire logic              host_wr_i,
   input wire logic              host_rd_i,
   input wire logic [1:0]        host_be_i,
   input wire logic [15:0]       host_wdata_i,
   input wire logic [15:0]       host_rdata_o,
   input wire logic              host_rvalid_o,
   // datapaths
   input wire logic              rx_pkt_valid_i,
   input wire logic [3:0]        rx_pkt_version_i,
   input wire logic              rx_verdict_valid_o,
   input wire verdict_t          rx_verdict_o,
   input wire logic              corr_valid_i,
   input wire logic              corr_ingress_i,
   input wire ptp_msg_t          corr_type_i,
   input wire logic [CORR_W-1:0] corr_i,
   input wire logic              corr_valid_o,
   input wire logic [CORR_W-1:0] corr_o,
   // settings
   input wire logic [15:0]       rx_latency_o,
   input wire logic [15:0]       tx_latency_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // ------------------------------------------------
   // host port
   // ------------------------------------------------
   sequence s_wr(a);
      host_wr_i && host_be_i == 2'b11 && host_addr_i == a;
   endsequence
   property p_rd_ans; host_rd_i |=> host_rvalid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read lost");
   property p_rd_quiet; !host_rd_i |=> !host_rvalid_o; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
   property p_resv;
      host_rd_i && host_addr_i == OFF_DOMAIN_VER |=> host_rdata_o[15:12] == 4'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_rx_wr; s_wr(OFF_RX_LAT) |=> rx_latency_o == $past(host_wdata_i); endproperty
   a_rx_wr: assert property (p_rx_wr) else $error("rx latency write lost");
   property p_tx_wr; s_wr(OFF_TX_LAT) |=> tx_latency_o == $past(host_wdata_i); endproperty
   a_tx_wr: assert property (p_tx_wr) else $error("tx latency write lost");
   property p_rx_hold;
      !(host_wr_i && host_addr_i == OFF_RX_LAT) |=> $stable(rx_latency_o);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx latency moved");
   // ------------------------------------------------
   // filter and correction
   // ------------------------------------------------
   property p_vd; rx_pkt_valid_i |=> rx_verdict_valid_o; endproperty
   a_vd: assert property (p_vd) else $error("verdict missing");
   property p_host_v1;
      rx_pkt_valid_i && rx_pkt_version_i != VER_HOST_OK |=> rx_verdict_o != VERDICT_HOST;
   endproperty
   a_host_v1: assert property (p_host_v1) else $error("non v1 frame to host");
   property p_corr_keep;
      corr_valid_i && !corr_ingress_i && corr_type_i == MSG_SYNC
         |=> corr_valid_o && corr_o == $past(corr_i);
   endproperty
   a_corr_keep: assert property (p_corr_keep) else $error("egress sync altered");
endmodule

bind ptp_port_timing_config ptp_cfg_monitor #(.CORR_W(CORR_W)) u_mon (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .host_addr_i(host_addr_i),
   .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_be_i(host_be_i),
   .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
   .rx_pkt_valid_i(rx_pkt_valid_i), .rx_pkt_version_i(rx_pkt_version_i),
   .rx_verdict_valid_o(rx_verdict_valid_o), .rx_verdict_o(rx_verdict_o),
   .corr_valid_i(corr_valid_i), .corr_ingress_i(corr_ingress_i), .corr_type_i(corr_type_i),
   .corr_i(corr_i), .corr_valid_o(corr_valid_o), .corr_o(corr_o),
   .rx_latency_o(rx_latency_o), .tx_latency_o(tx_latency_o)
);
`default_nettype wire

/* verif/host_cpu_model.sv */
// host processor model driving the register port
`default_nettype none
module host_cpu_model (
   // clock
   input  wire logic       sys_clk_i,
   // register port
   output var logic [10:0] host_addr_o,
   output var logic        host_wr_o,
   output var logic        host_rd_o,
   output var logic [1:0]  host_be_o,
   output var logic [15:0] host_wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      host_addr_o = 11'h000;
      host_wr_o = 1'b0;
      host_rd_o = 1'b0;
      host_be_o = 2'b00;
      host_wdata_o = 16'h0000;
   end
   // callers sit just after an edge; each request is held over exactly one edge
   task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic [1:0] be);
      host_addr_o = a;
      host_wdata_o = d;
      host_be_o = be;
      host_rd_o = 1'b0;
      host_wr_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic rd(input logic [10:0] a);
      host_addr_o = a;
      host_wr_o = 1'b0;
      host_rd_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
   endtask
   // idle lines toggle so nothing can lean on a stale value
   task automatic idle(input int n);
      repeat (n) begin
         host_wr_o = 1'b0;
         host_rd_o = 1'b0;
         host_addr_o = ~host_addr_o;
         host_wdata_o = ~host_wdata_o;
         @(posedge sys_clk_i);
         #1;
      end
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking testbench for the port-one ptp timing configuration block
`default_nettype none
module tb
   import ptp_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i = 1'b0, reset_i = 1'b1;
   logic [10:0] ha;
   logic hw, hr;
   logic [1:0] hb;
   logic [15:0] hd, rdata, rxl, txl, lkd;
   logic rvalid, pv, vv, cv, cing, cvo, tv;
   logic [3:0] pver;
   logic [7:0] pdom;
   verdict_t vd;
   ptp_msg_t ct, tt;
   logic [63:0] ci, co;
   logic [1:0] ts_s;
   logic [29:0] ts_n;
   logic [15:0] q_rd[$], tsl, tsh, asym = 16'h0000, r;
   verdict_t q_vd[$];
   logic [63:0] q_co[$];
   logic [3:0] ver = RST_VERSION;
   logic [7:0] dom = RST_DOMAIN;
   logic den = RST_DOMAIN_EN;
   int errors = 0, checks = 0;
   logic [10:0] RA[9] = '{OFF_MSG_CFG2, OFF_DOMAIN_VER, OFF_RX_LAT, OFF_TX_LAT, OFF_ASYM,
                          OFF_LINK_DLY, OFF_TS_LOW, OFF_TS_HIGH, 11'h630};
   logic [15:0] RV[9] = '{16'h0000, 16'h0200, 16'h019F, 16'h002D, 16'h0000, 16'h0000,
                          16'h0000, 16'h0000, 16'h0000};
   always #2.5 sys_clk_i = ~sys_clk_i;
   host_cpu_model u_host (.sys_clk_i(sys_clk_i), .host_addr_o(ha), .host_wr_o(hw),
      .host_rd_o(hr), .host_be_o(hb), .host_wdata_o(hd));
   ptp_port_timing_config DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .host_addr_i(ha),
      .host_wr_i(hw), .host_rd_i(hr), .host_be_i(hb), .host_wdata_i(hd), .host_rdata_o(rdata),
      .host_rvalid_o(rvalid), .rx_pkt_valid_i(pv), .rx_pkt_version_i(pver),
      .rx_pkt_domain_i(pdom), .rx_verdict_valid_o(vv), .rx_verdict_o(vd), .corr_valid_i(cv),
      .corr_ingress_i(cing), .corr_type_i(ct), .corr_i(ci), .corr_valid_o(cvo), .corr_o(co),
      .tx_ts_valid_i(tv), .tx_ts_type_i(tt), .tx_ts_sec_i(ts_s), .tx_ts_ns_i(ts_n),
      .rx_latency_o(rxl), .tx_latency_o(txl), .link_delay_o(lkd));
   // ------------------------------------------------
   // comparison
   // ------------------------------------------------
   task automatic note(input string w, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk_rd();
      if (q_rd.size() == 0) note("read data", 64'hX, {48'h0, rdata});
      else note("read data", {48'h0, q_rd.pop_front()}, {48'h0, rdata});
   endtask
   task automatic chk_vd();
      if (q_vd.size() == 0) note("verdict", 64'hX, {62'h0, vd});
      else note("verdict", {62'h0, q_vd.pop_front()}, {62'h0, vd});
   endtask
   task automatic chk_co();
      if (q_co.size() == 0) note("correction", 64'hX, co);
      else note("correction", q_co.pop_front(), co);
   endtask
   always @(posedge sys_clk_i) begin
      #1;
      if (rvalid === 1'b1) chk_rd();
      if (vv === 1'b1) chk_vd();
      if (cvo === 1'b1) chk_co();
   end
   // ------------------------------------------------
   // stimulus
   // ------------------------------------------------
   task automatic quiet();
      pv = 1'b0;
      cv = 1'b0;
      tv = 1'b0;
      pdom = ~pdom;
      ci = ~ci;
      ts_n = ~ts_n;
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      u_host.wr(a, d, 2'b11);
      u_host.idle(1);
   endtask
   task automatic rd(input logic [10:0] a, input logic [15:0] e);
      q_rd.push_back(e);
      u_host.rd(a);
      u_host.idle(1);
   endtask
   function automatic verdict_t vexp(input logic [3:0] v, input logic [7:0] d);
      if (v != ver) return VERDICT_DROP;
      if (ver != VER_HOST_OK) return VERDICT_LINE;
      if (den && d != dom) return VERDICT_DROP;
      return VERDICT_HOST;
   endfunction
   function automatic logic [63:0] cexp(input logic [63:0] c, input logic g, input ptp_msg_t t);
      logic [63:0] a;
      a = {49'h0, asym[14:0]};
      if (asym[15]) a = -a;
      if (g && (t == MSG_SYNC || t == MSG_PDELAY_RESP)) return c + a;
      if (!g && (t == MSG_DELAY_REQ || t == MSG_PDELAY_REQ)) return c - a;
      return c;
   endfunction
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic conclude();
      if (q_rd.size() + q_vd.size() + q_co.size() != 0) begin
         errors++;
         $display("[ERR] pending expected 0 seen %0d", q_rd.size() + q_vd.size() + q_co.size());
      end
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      conclude();
   end
   initial begin
      {pv, cv, cing, tv, pver, pdom, ci, ts_s, ts_n} = '0;
      ct = MSG_SYNC;
      tt = MSG_SYNC;
      void'($urandom(32'h6211));
      repeat (16) @(posedge sys_clk_i);
      #1;
      reset_i = 1'b0;
      foreach (RA[i]) rd(RA[i], RV[i]);
      done("reset values");
      for (int i = 2; i < 8; i++) begin
         r = 16'($urandom());
         if (i != 4) wr(RA[i], r);
         if (i != 4) rd(RA[i], r);
         if (i == 6) tsl = r;
         if (i == 7) tsh = r;
      end
      wr(OFF_LINK_DLY, r);
      u_host.wr(OFF_LINK_DLY, 16'hA5C3, 2'b01);
      u_host.idle(1);
      rd(OFF_LINK_DLY, {r[15:8], 8'hC3});
      note("link delay", {48'h0, r[15:8], 8'hC3}, {48'h0, lkd});
      wr(11'h630, 16'hFFFF);
      rd(11'h630, 16'h0000);
      wr(OFF_DOMAIN_VER, 16'hFFFF);
      rd(OFF_DOMAIN_VER, 16'h0FFF);
      done("register access");
      for (int k = 0; k < 4; k++) begin
         ver = (k < 2) ? 4'h2 + 4'(k * 13) : VER_HOST_OK;
         dom = 8'($urandom());
         den = k[0];
         wr(OFF_DOMAIN_VER, {4'h0, ver, dom});
         wr(OFF_MSG_CFG2, {11'h0, den, 4'h0});
         for (int j = 0; j < 16; j++) begin
            pv = 1'b1;
            pver = j[1] ? ver : 4'($urandom());
            pdom = j[0] ? dom : 8'($urandom());
            q_vd.push_back(vexp(pver, pdom));
            @(posedge sys_clk_i);
            #1;
         end
         quiet();
      end
      done("frame filter");
      for (int k = 0; k < 3; k++) begin
         asym = (k == 1) ? 16'hFFFF : {k[1], 15'($urandom())};
         wr(OFF_ASYM, asym);
         for (int j = 0; j < 8; j++) begin
            cv = 1'b1;
            cing = j[2];
            ct = ptp_msg_t'(j[1:0]);
            ci = {$urandom(), $urandom()};
            q_co.push_back(cexp(ci, cing, ct));
            @(posedge sys_clk_i);
            #1;
         end
         quiet();
      end
      done("asymmetry correction");
      for (int j = 0; j < 8; j++) begin
         tv = 1'b1;
         tt = ptp_msg_t'(j[1:0]);
         ts_s = 2'($urandom());
         ts_n = 30'($urandom());
         if (tt == MSG_DELAY_REQ || tt == MSG_PDELAY_REQ) {tsh, tsl} = {ts_s, ts_n};
         @(posedge sys_clk_i);
         #1;
         quiet();
         rd(OFF_TS_LOW, tsl);
         rd(OFF_TS_HIGH, tsh);
      end
      done("egress timestamp");
      reset_i = 1'b1;
      u_host.idle(2);
      reset_i = 1'b0;
      rd(OFF_RX_LAT, 16'h019F);
      rd(OFF_TS_HIGH, 16'h0000);
      done("second reset");
      conclude();
   end
endmodule
`default_nettype wire
